/* File: core/uc_cache_wbuf.sv */
`timescale 1ns/1ps
`default_nettype none
module uc_cache_wbuf #(
  parameter int WBUF_DEPTH = uc_pkg::WBUF_DEPTH
) (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_b_i,
  // Control bits
  input  wire logic                       cache_en_i,
  input  wire logic                       wbuf_en_i,
  input  wire logic                       cache_flush_i,
  // Core request, held until acknowledged
  input  wire logic                       req_valid_i,
  input  var  uc_pkg::uc_req_t            req_i,
  output logic                            core_ack_o,
  output logic [uc_pkg::DATA_W-1:0]       core_rdata_o,
  output logic                            core_err_o,
  // Bus master
  output var  uc_pkg::uc_ahb_out_t        ahb_o,
  input  wire logic                       hready_i,
  input  wire logic [1:0]                 hresp_i,
  input  wire logic [uc_pkg::DATA_W-1:0]  hrdata_i
);
  localparam int PTR_W = $clog2(WBUF_DEPTH);
  // ==========================================================
  // Address helpers
  function automatic logic [uc_pkg::SET_W-1:0] set_of(
    input logic [uc_pkg::ADDR_W-1:0] a);
    set_of = a[uc_pkg::OFF_W +: uc_pkg::SET_W];
  endfunction : set_of
  function automatic logic [uc_pkg::TAG_W-1:0] tag_of(
    input logic [uc_pkg::ADDR_W-1:0] a);
    tag_of = a[uc_pkg::ADDR_W-1 -: uc_pkg::TAG_W];
  endfunction : tag_of
  function automatic logic [11:0] word_idx(
    input logic [uc_pkg::SET_W-1:0]  s,
    input logic [uc_pkg::WAY_W-1:0]  w,
    input logic [uc_pkg::WORD_W-1:0] k);
    word_idx = {s, w, k};
  endfunction : word_idx
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DRAIN = 3'b001,
    ST_BUS   = 3'b010,
    ST_DONE  = 3'b011
  } uc_state_t;
  typedef enum logic [1:0] {
    OP_FILL  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } uc_op_t;
  // ==========================================================
  // Storage
  logic [uc_pkg::DATA_W-1:0] data_mem [0:uc_pkg::LINES*uc_pkg::LINE_WORDS-1];
  logic [uc_pkg::TAG_W-1:0]  tag_mem  [0:uc_pkg::LINES-1];
  logic [uc_pkg::LINES-1:0]  valid_q;
  logic [uc_pkg::ADDR_W-1:0] wb_addr  [0:WBUF_DEPTH-1];
  logic [uc_pkg::DATA_W-1:0] wb_data  [0:WBUF_DEPTH-1];
  uc_state_t                 state_q;
  uc_op_t                    op_q;
  logic [uc_pkg::WAY_W-1:0]  victim_q;
  logic [7:0]                lfsr_q;
  logic [PTR_W-1:0]          wr_ptr_q;
  logic [PTR_W-1:0]          rd_ptr_q;
  logic [PTR_W:0]            count_q;
  logic                      eng_busy_q;
  logic                      eng_fill_q;
  logic                      eng_wbuf_q;
  logic                      eng_done_q;
  logic                      eng_err_q;
  logic                      dph_q;
  logic [3:0]                acnt_q;
  logic [3:0]                dcnt_q;
  logic [3:0]                total_q;
  logic [uc_pkg::DATA_W-1:0] eng_wdata_q;
  uc_pkg::uc_ahb_out_t       ahb_q;
  logic                      ack_q;
  logic                      err_q;
  logic [uc_pkg::DATA_W-1:0] rdata_q;
  logic [uc_pkg::SET_W-1:0]  req_set;
  logic                      hit;
  logic [uc_pkg::WAY_W-1:0]  hit_way;
  logic                      cache_on;
  logic                      buffered;
  logic                      wb_full;
  logic                      wb_empty;
  logic                      push;
  logic                      fsm_start;
  logic                      wb_start;
  logic                      beat_done;
  logic                      last_beat;
  // ==========================================================
  // Lookup
  assign req_set  = set_of(req_i.addr);
  assign cache_on = cache_en_i;
  assign wb_full  = (count_q == (PTR_W+1)'(WBUF_DEPTH));
  assign wb_empty = (count_q == '0);
  assign buffered = wbuf_en_i && req_i.bufferable && !req_i.lock;
  always_comb begin
    hit     = 1'b0;
    hit_way = '0;
    for (int w = 0; w < uc_pkg::WAYS; w++) begin
      if (valid_q[{req_set, w[uc_pkg::WAY_W-1:0]}] &&
          tag_mem[{req_set, w[uc_pkg::WAY_W-1:0]}] == tag_of(req_i.addr)) begin
        hit     = 1'b1;
        hit_way = w[uc_pkg::WAY_W-1:0];
      end
    end
  end
  assign push      = (state_q == ST_IDLE) && req_valid_i && req_i.write &&
                     buffered && !wb_full;
  assign fsm_start = (state_q == ST_DRAIN) && wb_empty && !eng_busy_q;
  assign wb_start  = !eng_busy_q && !wb_empty && !fsm_start;
  assign beat_done = eng_busy_q && hready_i && dph_q;
  assign last_beat = beat_done && (dcnt_q == total_q - 4'h1);
  // ==========================================================
  // Request sequencer
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q  <= ST_IDLE;
      op_q     <= OP_READ;
      victim_q <= '0;
      ack_q    <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (req_valid_i) begin
            err_q <= 1'b0;
            if (req_i.write && buffered) begin
              if (!wb_full) begin
                state_q <= ST_DONE;
                ack_q   <= 1'b1;
              end
            end else if (!req_i.write && cache_on && req_i.cachable &&
                         !req_i.lock && hit) begin
              state_q <= ST_DONE;
              ack_q   <= 1'b1;
            end else begin
              if (req_i.write)
                op_q <= OP_WRITE;
              else if (cache_on && req_i.cachable && !req_i.lock)
                op_q <= OP_FILL;
              else
                op_q <= OP_READ;
              victim_q <= lfsr_q[uc_pkg::WAY_W-1:0];
              state_q  <= ST_DRAIN;
            end
          end
        end
        ST_DRAIN: if (fsm_start) state_q <= ST_BUS;
        ST_BUS: begin
          if (eng_done_q && !eng_wbuf_q) begin
            state_q <= ST_DONE;
            ack_q   <= 1'b1;
            err_q   <= eng_err_q && (op_q != OP_FILL);
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // Free-running source for way choice
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      lfsr_q <= uc_pkg::LFSR_RESET;
    else
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  // ==========================================================
  // Write buffer, strict first in first out
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      wb_addr[wr_ptr_q] <= req_i.addr;
      wb_data[wr_ptr_q] <= req_i.wdata;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == PTR_W'(WBUF_DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      if (wb_start)
        rd_ptr_q <= (rd_ptr_q == PTR_W'(WBUF_DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(wb_start);
    end
  end
  // ==========================================================
  // Bus engine: one owner at a time, address then data phase
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ahb_q       <= '0;
      eng_busy_q  <= 1'b0;
      eng_fill_q  <= 1'b0;
      eng_wbuf_q  <= 1'b0;
      eng_done_q  <= 1'b0;
      eng_err_q   <= 1'b0;
      dph_q       <= 1'b0;
      acnt_q      <= '0;
      dcnt_q      <= '0;
      total_q     <= uc_pkg::BEATS_SINGLE;
      eng_wdata_q <= '0;
    end else begin
      eng_done_q <= 1'b0;
      if (!eng_busy_q && (fsm_start || wb_start)) begin
        eng_busy_q    <= 1'b1;
        eng_wbuf_q    <= !fsm_start;
        eng_fill_q    <= fsm_start && (op_q == OP_FILL);
        eng_err_q     <= 1'b0;
        acnt_q        <= 4'h1;
        dcnt_q        <= '0;
        dph_q         <= 1'b0;
        ahb_q.htrans  <= uc_pkg::HTRANS_NONSEQ;
        ahb_q.hsize   <= uc_pkg::HSIZE_WORD;
        if (fsm_start) begin
          ahb_q.hwrite <= (op_q == OP_WRITE);
          eng_wdata_q  <= req_i.wdata;
          ahb_q.hlock  <= ahb_q.hlock || req_i.lock;
          if (op_q == OP_FILL) begin
            ahb_q.haddr  <= {req_i.addr[uc_pkg::ADDR_W-1:uc_pkg::OFF_W],
                             {uc_pkg::OFF_W{1'b0}}};
            ahb_q.hburst <= uc_pkg::HBURST_INCR8;
            total_q      <= uc_pkg::BEATS_LINE;
          end else begin
            ahb_q.haddr  <= req_i.addr;
            ahb_q.hburst <= uc_pkg::HBURST_SINGLE;
            total_q      <= uc_pkg::BEATS_SINGLE;
          end
        end else begin
          ahb_q.hwrite <= 1'b1;
          ahb_q.haddr  <= wb_addr[rd_ptr_q];
          eng_wdata_q  <= wb_data[rd_ptr_q];
          ahb_q.hburst <= uc_pkg::HBURST_SINGLE;
          total_q      <= uc_pkg::BEATS_SINGLE;
        end
      end else if (eng_busy_q && hready_i) begin
        if (dph_q) begin
          dcnt_q <= dcnt_q + 4'h1;
          // Buffered writes cannot be aborted, so their error is dropped
          if (hresp_i == uc_pkg::HRESP_ERROR && !eng_wbuf_q)
            eng_err_q <= 1'b1;
          if (dcnt_q == total_q - 4'h1) begin
            eng_busy_q <= 1'b0;
            eng_done_q <= 1'b1;
            // Lock released only once the write half has finished
            if (!eng_wbuf_q && ahb_q.hwrite)
              ahb_q.hlock <= 1'b0;
          end
        end
        if (ahb_q.htrans != uc_pkg::HTRANS_IDLE) begin
          dph_q        <= 1'b1;
          ahb_q.hwdata <= eng_wdata_q;
          if (acnt_q < total_q) begin
            acnt_q       <= acnt_q + 4'h1;
            ahb_q.htrans <= uc_pkg::HTRANS_SEQ;
            ahb_q.haddr  <= ahb_q.haddr + 32'h4;
          end else begin
            ahb_q.htrans <= uc_pkg::HTRANS_IDLE;
          end
        end else begin
          dph_q <= 1'b0;
        end
      end
    end
  end
  // ==========================================================
  // Cache arrays
  always_ff @(posedge core_clk_i) begin
    if (fsm_start && op_q == OP_FILL)
      tag_mem[{req_set, victim_q}] <= tag_of(req_i.addr);
    if (beat_done && eng_fill_q)
      data_mem[word_idx(req_set, victim_q, dcnt_q[uc_pkg::WORD_W-1:0])]
        <= hrdata_i;
    else if ((push || (last_beat && !eng_wbuf_q && ahb_q.hwrite)) && hit)
      data_mem[word_idx(req_set, hit_way, req_i.addr[4:2])]
        <= req_i.wdata;
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_q <= '0;
    end else if (cache_flush_i) begin
      valid_q <= '0;
    end else begin
      // Victim is dead for the whole fill, so a stale hit cannot occur
      if (fsm_start && op_q == OP_FILL)
        valid_q[{req_set, victim_q}] <= 1'b0;
      if (last_beat && eng_fill_q)
        valid_q[{req_set, victim_q}] <= 1'b1;
    end
  end
  // ==========================================================
  // Read data to the core
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else if (state_q == ST_IDLE && req_valid_i && !req_i.write &&
                 cache_on && req_i.cachable && !req_i.lock && hit) begin
      rdata_q <= data_mem[word_idx(req_set, hit_way, req_i.addr[4:2])];
    end else if (beat_done && !eng_wbuf_q && !ahb_q.hwrite) begin
      if (!eng_fill_q ||
          dcnt_q[uc_pkg::WORD_W-1:0] == req_i.addr[4:2])
        rdata_q <= hrdata_i;
    end
  end
  assign core_ack_o   = ack_q;
  assign core_err_o   = err_q;
  assign core_rdata_o = rdata_q;
  assign ahb_o        = ahb_q;
endmodule : uc_cache_wbuf
`default_nettype wire

/* File: core/uc_pkg.sv */
package uc_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 32;
  localparam int LINES      = 512;
  localparam int WAYS       = 4;
  localparam int LINE_WORDS = 8;
  localparam int SETS       = LINES / WAYS;
  localparam int WAY_W      = 2;
  localparam int SET_W      = 7;
  localparam int WORD_W     = 3;
  localparam int OFF_W      = 5;
  localparam int TAG_W      = ADDR_W - SET_W - OFF_W;
  localparam int WBUF_DEPTH = 8;

  // ==========================================================
  // Bus encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_INCR8  = 3'h5;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic [1:0] HRESP_ERROR   = 2'h1;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] LFSR_RESET   = 8'ha5;
  localparam logic [3:0] BEATS_SINGLE = 4'h1;
  localparam logic [3:0] BEATS_LINE   = 4'h8;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              cachable;
    logic              bufferable;
    logic              lock;
  } uc_req_t;

  typedef struct packed {
    logic [1:0]        htrans;
    logic [ADDR_W-1:0] haddr;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [2:0]        hburst;
    logic              hlock;
    logic [DATA_W-1:0] hwdata;
  } uc_ahb_out_t;

endpackage : uc_pkg

/* File: bench/uc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module uc_checker (
  // Clock and reset
  input wire logic                core_clk_i,
  input wire logic                rst_b_i,
  // Control and core side
  input wire logic                cache_en_i,
  input wire logic                wbuf_en_i,
  input wire logic                req_valid_i,
  input var  uc_pkg::uc_req_t     req_i,
  input wire logic                core_ack_o,
  // Bus side
  input var  uc_pkg::uc_ahb_out_t ahb_o,
  input wire logic                hready_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Core side
  property p_ack_pulse; core_ack_o |=> !core_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  // Hit path acks after one cycle, so three quiet cycles prove a bus trip
  property p_unbuf_wait; $rose(req_valid_i) && req_i.write &&
    (!wbuf_en_i || !req_i.bufferable || req_i.lock) |-> !core_ack_o [*3];
  endproperty
  a_unbuf_wait: assert property (p_unbuf_wait)
    else $error("unbuffered write acked too early");
  property p_rd_ext; $rose(req_valid_i) && !req_i.write &&
    (!req_i.cachable || req_i.lock) |-> !core_ack_o [*3]; endproperty
  a_rd_ext: assert property (p_rd_ext)
    else $error("external read acked too early");
  // ==========================================================
  // Bus side
  property p_hold; ahb_o.htrans != uc_pkg::HTRANS_IDLE && !hready_i |=>
    $stable(ahb_o.haddr) && $stable(ahb_o.htrans); endproperty
  a_hold: assert property (p_hold)
    else $error("address phase changed in wait state");
  property p_wr_single; ahb_o.hwrite && ahb_o.htrans != uc_pkg::HTRANS_IDLE
    |-> ahb_o.htrans == uc_pkg::HTRANS_NONSEQ &&
        ahb_o.hburst == uc_pkg::HBURST_SINGLE; endproperty
  a_wr_single: assert property (p_wr_single)
    else $error("write not a single nonsequential transfer");
  property p_fill_base; ahb_o.htrans == uc_pkg::HTRANS_NONSEQ &&
    ahb_o.hburst == uc_pkg::HBURST_INCR8 |-> ahb_o.haddr[4:0] == 5'h0 &&
    !ahb_o.hwrite; endproperty
  a_fill_base: assert property (p_fill_base)
    else $error("line fill not from line base");
  property p_fill_en; ahb_o.htrans == uc_pkg::HTRANS_NONSEQ &&
    ahb_o.hburst == uc_pkg::HBURST_INCR8 |-> cache_en_i; endproperty
  a_fill_en: assert property (p_fill_en)
    else $error("line fill with cache disabled");
  property p_seq_inc; $past(hready_i) && ahb_o.htrans == uc_pkg::HTRANS_SEQ
    |-> ahb_o.haddr == $past(ahb_o.haddr) + 32'h4; endproperty
  a_seq_inc: assert property (p_seq_inc)
    else $error("fill beat address not incremented");
  property p_lock_rise; $rose(ahb_o.hlock) |->
    ahb_o.htrans == uc_pkg::HTRANS_NONSEQ && !ahb_o.hwrite; endproperty
  a_lock_rise: assert property (p_lock_rise)
    else $error("bus lock not raised with locked read");
endmodule : uc_checker

bind uc_cache_wbuf uc_checker chk_u (.core_clk_i, .rst_b_i, .cache_en_i,
  .wbuf_en_i, .req_valid_i, .req_i, .core_ack_o, .ahb_o, .hready_i);
`default_nettype wire

/* File: bench/uc_ahb_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module uc_ahb_mem (
  // Clock and reset
  input wire logic                clk_i,
  input wire logic                rst_b_i,
  // Behaviour select
  input wire logic                slow_i,
  input wire logic                err_i,
  // Bus
  input var  uc_pkg::uc_ahb_out_t ahb_i,
  output logic                    hready_o,
  output logic [1:0]              hresp_o,
  output logic [31:0]             hrdata_o
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wlog [$];
  logic [31:0] dadr, a;
  logic        dph, dwr, nph, w, act;
  logic [2:0]  cnt;
  function automatic logic [31:0] rd(input logic [31:0] x);
    return mem.exists(x) ? mem[x] : ~x;
  endfunction : rd
  // Slow mode inserts seven wait states so the buffer can fill
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dph <= 1'b0;
      dwr <= 1'b0;
      dadr <= '0;
      cnt = 3'h0;
      hready_o <= 1'b1;
      hresp_o <= 2'h0;
      hrdata_o <= '0;
    end else begin
      nph = hready_o && ahb_i.htrans[1];
      if (dph && hready_o && dwr) begin
        mem[dadr] = ahb_i.hwdata;
        wlog.push_back(dadr);
      end
      a = nph ? ahb_i.haddr : dadr;
      w = nph ? ahb_i.hwrite : dwr;
      act = nph || (dph && !hready_o);
      cnt = nph ? (slow_i ? 3'h7 : {2'h0, err_i && w}) : cnt - 3'h1;
      if (nph) begin
        dadr <= ahb_i.haddr;
        dwr <= ahb_i.hwrite;
      end
      dph <= act;
      hready_o <= !act || cnt == 3'h0;
      hresp_o <= (act && err_i && w) ? uc_pkg::HRESP_ERROR : 2'h0;
      // Released read data toggles so it is never mistaken for valid
      hrdata_o <= (act && !w && cnt == 3'h0) ? rd(a) : ~hrdata_o;
    end
  end
endmodule : uc_ahb_mem
`default_nettype wire

/* File: bench/uc_testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                core_clk_i = 1'b0;
  logic                rst_b_i, cache_en_i, wbuf_en_i, cache_flush_i;
  logic                req_valid_i, slow_i, err_i, er;
  logic                core_ack_o, core_err_o, hready_i;
  logic [31:0]         core_rdata_o, hrdata_i, rd, a;
  logic [1:0]          hresp_i;
  uc_pkg::uc_req_t     req_i;
  uc_pkg::uc_ahb_out_t ahb_o;
  logic [31:0]         ref_mem [logic [31:0]];
  logic [31:0]         exq [$];
  int                  miscompares = 0, checked = 0, maxn;

  always #5 core_clk_i = ~core_clk_i;

  uc_cache_wbuf dut (.core_clk_i, .rst_b_i, .cache_en_i, .wbuf_en_i,
    .cache_flush_i, .req_valid_i, .req_i, .core_ack_o, .core_rdata_o,
    .core_err_o, .ahb_o, .hready_i, .hresp_i, .hrdata_i);
  uc_ahb_mem mem_u (.clk_i(core_clk_i), .rst_b_i, .slow_i, .err_i,
    .ahb_i(ahb_o), .hready_o(hready_i), .hresp_o(hresp_i),
    .hrdata_o(hrdata_i));

  // ==========================================================
  // Helpers
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [31:0] exp_rd(input logic [31:0] x);
    return ref_mem.exists(x) ? ref_mem[x] : ~x;
  endfunction : exp_rd

  task automatic acc(input logic w, input logic [31:0] ad,
                     input logic [31:0] d, input logic c, input logic b,
                     input logic l);
    int n;
    @(negedge core_clk_i);
    req_i = '{w, ad, d, c, b, l};
    req_valid_i = 1'b1;
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (core_ack_o !== 1'b1 && n < 2000);
    chk("ack", 1, core_ack_o);
    req_valid_i = 1'b0;
    rd = core_rdata_o;
    er = core_err_o;
    if (n > maxn) maxn = n;
    if (w) begin
      exq.push_back(ad);
      ref_mem[ad] = d;
    end
  endtask : acc

  // Uncached read drains the buffer before the log is compared
  task automatic drain_order;
    acc(0, 32'h8000, 0, 0, 0, 0);
    chk("uncached read", exp_rd(32'h8000), rd);
    chk("write count", exq.size(), mem_u.wlog.size());
    foreach (exq[i]) chk("write addr", exq[i], mem_u.wlog[i]);
    exq.delete();
    mem_u.wlog.delete();
  endtask : drain_order

  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    #500000;
    miscompares++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    void'($urandom(32'h3eec));
    {rst_b_i, cache_en_i, wbuf_en_i, cache_flush_i} = 4'h0;
    {req_valid_i, slow_i, err_i} = 3'h0;
    req_i = '0;
    repeat (16) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    chk("reset ack", 0, core_ack_o);
    chk("reset htrans", 0, ahb_o.htrans);
    chk("reset hlock", 0, ahb_o.hlock);
    $display("test reset done");
    cache_en_i = 1'b1;
    wbuf_en_i = 1'b1;
    for (int i = 0; i < 60; i++) begin
      a = 32'h1000 + 32'($urandom % 64) * 4;
      slow_i = 1'($urandom % 2);
      if ($urandom % 2) acc(1, a, $urandom, 1, 1'($urandom % 2), 0);
      else begin
        acc(0, a, 0, 1, 0, 0);
        chk("read", exp_rd(a), rd);
      end
    end
    drain_order();
    $display("test random traffic done");
    slow_i = 1'b1;
    err_i = 1'b1;
    maxn = 0;
    for (int i = 0; i < 16; i++) begin
      acc(1, 32'h2000 + 32'(i) * 4, 32'(i), 1, 1, 0);
      chk("buffered err", 0, er);
    end
    chk("full stall", 1, maxn > 2);
    wbuf_en_i = 1'b0;
    acc(1, 32'h2100, 32'h55, 1, 1, 0);
    chk("unbuffered err", 1, er);
    {slow_i, err_i} = 2'h0;
    drain_order();
    $display("test buffer full done");
    wbuf_en_i = 1'b1;
    a = 32'h3000;
    acc(0, a, 0, 1, 0, 0);
    chk("fill", ~a, rd);
    mem_u.mem[a] = 32'h1111;
    acc(0, a, 0, 1, 0, 0);
    chk("hit", ~a, rd);
    acc(0, a, 0, 0, 0, 0);
    chk("uncached", 32'h1111, rd);
    acc(0, a, 0, 1, 0, 0);
    chk("no alloc", ~a, rd);
    acc(0, a, 0, 1, 0, 1);
    chk("locked read", 32'h1111, rd);
    chk("hlock held", 1, ahb_o.hlock);
    err_i = 1'b1;
    acc(1, a, 32'h2222, 1, 1, 1);
    chk("swap err", 1, er);
    err_i = 1'b0;
    acc(0, a, 0, 1, 0, 0);
    chk("locked write", 32'h2222, rd);
    mem_u.mem[a] = 32'h3333;
    ref_mem[a] = 32'h3333;
    @(negedge core_clk_i);
    cache_flush_i = 1'b1;
    @(negedge core_clk_i);
    cache_flush_i = 1'b0;
    acc(0, a, 0, 1, 0, 0);
    chk("after flush", 32'h3333, rd);
    $display("test lock and flush done");
    cache_en_i = 1'b0;
    a = 32'h4000;
    acc(0, a, 0, 1, 0, 0);
    mem_u.mem[a] = 32'h4444;
    acc(0, a, 0, 1, 0, 0);
    chk("disabled", 32'h4444, rd);
    ref_mem[a] = 32'h4444;
    drain_order();
    $display("test cache disabled done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
